// File: dv/mhp_host_model.sv
// host side of the multi-function pins
`timescale 1ns/1ps
module mhp_host_model (
  input wire logic i_sys_clk,
  output logic [3:0] o_drv
);
  logic rel;
  logic online_exit_input;
  logic ser;
  initial begin
    rel = 1'b0;
    online_exit_input = 1'b0;
    ser = 1'b1;
  end
  // released pins toggle so a stale level never passes for a driven one
  always @(posedge i_sys_clk) rel <= ~rel;
  assign o_drv = {rel, online_exit_input, ser, rel};
  // held four cycles so the synchroniser cannot miss it
  task automatic escape;
    online_exit_input <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    online_exit_input <= 1'b0;
  endtask : escape
  task automatic send(input logic b);
    ser <= b;
  endtask : send
endmodule : mhp_host_model

// File: dv/mhp_pin_monitor.sv
// concurrent checks on the pin function block ports
`timescale 1ns/1ps
module mhp_pin_monitor
  import mhp_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire mhp_apb_req_type i_apb,
  input wire logic o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  input wire mhp_pins_type o_pins,
  input wire logic o_divided_clock_out,
  input wire logic i_connect,
  input wire logic i_carrier_lost,
  input wire logic i_rx_space,
  input wire logic o_cts,
  input wire logic o_online,
  input wire logic o_sleep,
  input wire logic o_irq
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  a_ready_wait: assert property ($rose(i_apb.penable) && i_apb.psel
    |=> o_pready) else $error("no ready one cycle into access");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  a_err_zero: assert property (o_pready && o_pslverr
    |-> o_prdata == 32'h0) else $error("error read not zero");
  a_cts_on: assert property (i_rx_space && !o_sleep |=> o_cts)
    else $error("cts low with room");
  a_cts_off: assert property (!i_rx_space || o_sleep |=> !o_cts)
    else $error("cts high without room");
  a_reset_vals: assert property (disable iff (1'b0)
    !i_resetn |=> !o_online && !o_sleep && !o_irq && o_pins.oe == 4'h0)
    else $error("reset values wrong");
  // every legal divider gives a half period of at least two cycles
  a_clk_min: assert property ($changed(o_divided_clock_out)
    |=> $stable(o_divided_clock_out)) else $error("short clock pulse");
  a_loss_drop: assert property (i_carrier_lost && !i_connect
    |=> !o_online) else $error("online after loss");
  a_conn_up: assert property (i_connect && !i_carrier_lost
    |=> o_online) else $error("connect ignored");
  a_evt_hold: assert property (o_pins.dout[3] && o_pins.oe[3]
    && !o_pready && !$past(o_pready) |=> o_pins.dout[3])
    else $error("line event dropped");
endmodule : mhp_pin_monitor

bind mhp_pin_functions mhp_pin_monitor u_mon (.i_sys_clk(i_sys_clk),
  .i_resetn(i_resetn), .i_apb(i_apb), .o_pready(o_pready),
  .o_prdata(o_prdata), .o_pslverr(o_pslverr), .o_pins(o_pins),
  .o_divided_clock_out(o_divided_clock_out), .i_connect(i_connect),
  .i_carrier_lost(i_carrier_lost), .i_rx_space(i_rx_space),
  .o_cts(o_cts), .o_online(o_online), .o_sleep(o_sleep), .o_irq(o_irq));

// File: dv/testbench.sv
// self-checking bench of the pin function block
`timescale 1ns/1ps
module testbench;
  import mhp_pkg::*;
  logic clk, rstn, rdy, err, sin, cts, onl, slp, irq, clko;
  logic sout, rx_frame_end_flag, conn, loss, intr, space;
  logic [31:0] rdat, v;
  logic [3:0] drv, pins;
  mhp_apb_req_type req;
  mhp_pins_type po;
  int num_errors, total_checks, c;
  assign pins = (po.oe & po.dout) | (~po.oe & drv);
  mhp_host_model u_host (.i_sys_clk(clk), .o_drv(drv));
  mhp_pin_functions u_dut (.i_sys_clk(clk), .i_resetn(rstn), .i_apb(req),
    .o_pready(rdy), .o_prdata(rdat), .o_pslverr(err), .i_pins(pins),
    .o_pins(po), .o_divided_clock_out(clko),
    .i_secondary_serial_out(sout), .o_secondary_serial_in(sin),
    .i_rx_frame_end_flag(rx_frame_end_flag), .i_connect(conn), .i_carrier_lost(loss),
    .i_intrusion(intr), .i_rx_space(space), .o_cts(cts), .o_online(onl),
    .o_sleep(slp), .o_irq(irq));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic test_done;
    if (num_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    req.psel <= 1'b1;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    r = rdat;
    e = err;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic e;
    apb(1'b1, a, d, v, e);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic e;
    apb(1'b0, a, 32'h0, v, e);
  endtask : rd
  task automatic do_reset;
    rstn <= 1'b0;
    tick(4);
    rstn <= 1'b1;
    tick(1);
  endtask : do_reset
  task automatic half;
    logic s;
    s = clko;
    c = 0;
    while (clko === s && c < 99) begin
      tick(1);
      c++;
    end
    s = clko;
    c = 0;
    while (clko === s && c < 99) begin
      tick(1);
      c++;
    end
  endtask : half
  task automatic t_defaults;
    logic e;
    rd(OFS_DIVIDER);
    chk(v, 32'h7);
    rd(OFS_PIN_FUNC);
    chk(v, 32'h0);
    chk(po.oe, 4'h0);
    apb(1'b0, 8'h3C, 32'h0, v, e);
    chk(e, 1'b1);
    chk(v, 32'h0);
  endtask : t_defaults
  task automatic t_clock;
    logic bad;
    wr(OFS_DIVIDER, 32'h1);
    repeat (3) half;
    chk(c, 2);
    wr(OFS_DIVIDER, 32'h0);
    tick(20);
    bad = 1'b0;
    repeat (20) begin
      tick(1);
      bad |= clko !== 1'b0;
    end
    chk(bad, 1'b0);
    wr(OFS_DIVIDER, 32'h3);
    repeat (3) half;
    chk(c, 4);
  endtask : t_clock
  task automatic t_pins;
    wr(OFS_MODE, 32'h1);
    u_host.send(1'b0);
    sout <= 1'b1;
    tick(4);
    chk(sin, 1'b0);
    chk({po.oe[0], po.dout[0]}, 2'h3);
    wr(OFS_MODE, 32'h3);
    sout <= 1'b0;
    rx_frame_end_flag <= 1'b1;
    tick(3);
    chk(po.dout[0], 1'b1);
    rx_frame_end_flag <= 1'b0;
    wr(OFS_MODE, 32'h0);
    u_host.send(1'b1);
    wr(OFS_GPIO_DIR, 32'h1);
    wr(OFS_GPIO_OUT, 32'h1);
    tick(2);
    chk({po.oe[0], po.dout[0]}, 2'h3);
    rd(OFS_GPIO_IN);
    chk(v & 32'h2, 32'h2);
  endtask : t_pins
  task automatic pulse_conn;
    conn <= 1'b1;
    tick(1);
    conn <= 1'b0;
    tick(2);
  endtask : pulse_conn
  task automatic t_escape;
    wr(OFS_IRQ_CLR, 32'h7);
    wr(OFS_PIN_FUNC, 32'h08);
    pulse_conn;
    chk(onl, 1'b1);
    u_host.escape;
    tick(3);
    chk(onl, 1'b0);
    rd(OFS_IRQ_STAT);
    chk(v, 32'h1);
    wr(OFS_IRQ_EN, 32'h1);
    tick(2);
    chk(irq, 1'b1);
    wr(OFS_IRQ_EN, 32'h0);
    tick(2);
    chk(irq, 1'b0);
    wr(OFS_IRQ_CLR, 32'h1);
    rd(OFS_IRQ_STAT);
    chk(v, 32'h0);
  endtask : t_escape
  task automatic t_event;
    wr(OFS_PIN_FUNC, 32'hC0);
    pulse_conn;
    chk({po.oe[3], po.dout[3]}, 2'h2);
    loss <= 1'b1;
    tick(1);
    loss <= 1'b0;
    tick(12);
    chk(po.dout[3], 1'b1);
    rd(OFS_IRQ_STAT);
    chk(v, 32'h6);
    wr(OFS_PIN_FUNC, 32'hC0);
    tick(2);
    chk(po.dout[3], 1'b0);
    intr <= 1'b1;
    tick(1);
    intr <= 1'b0;
    tick(2);
    chk(po.dout[3], 1'b1);
  endtask : t_event
  task automatic t_sleep;
    wr(OFS_MODE, 32'h4);
    tick(2);
    chk({slp, cts}, 2'h2);
    wr(OFS_MODE, 32'h0);
    tick(2);
    chk(cts, 1'b1);
    space <= 1'b0;
    tick(2);
    chk(cts, 1'b0);
    space <= 1'b1;
    tick(2);
    chk(cts, 1'b1);
    wr(OFS_MODE, 32'h4);
    do_reset;
    chk(slp, 1'b0);
    rd(OFS_DIVIDER);
    chk(v, 32'h7);
  endtask : t_sleep
  initial begin
    req = '0;
    {rstn, sout, rx_frame_end_flag, conn, loss, intr} = '0;
    space = 1'b1;
    do_reset;
    t_defaults;
    t_clock;
    t_pins;
    t_escape;
    t_event;
    t_sleep;
    test_done;
  end
  // the whole run needs well under ten thousand cycles
  initial begin
    #(40 * 20000);
    num_errors++;
    test_done;
  end
endmodule : testbench

// File: rtl/mhp_clk_div.sv
// programmable divided clock generator, glitch free on divider change
`timescale 1ns/1ps
module mhp_clk_div
  import mhp_pkg::*;
#(
  parameter int DIV_WIDTH = DIV_W
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [DIV_WIDTH-1:0] i_div_n,
  output logic o_clk
);
  // the reset value seven needs three bits; counters wider than eight bits are not served
  if (DIV_WIDTH < 3 || DIV_WIDTH > 8) begin : g_bad_width
    $error("mhp_clk_div: DIV_WIDTH out of range");
  end

  logic [DIV_WIDTH-1:0] cnt_q, cnt_d;
  logic [DIV_WIDTH-1:0] n_q, n_d;
  logic clk_q, clk_d;

  always_comb begin
    cnt_d = cnt_q;
    n_d = n_q;
    clk_d = clk_q;
    if (n_q == DIV_WIDTH'(0)) begin
      // stopped: output parked low, a new value starts a fresh period
      clk_d = 1'b0;
      cnt_d = '0;
      n_d = i_div_n;
    end else if (cnt_q == n_q) begin
      cnt_d = '0;
      clk_d = ~clk_q;
      // take a new divider only as a full period ends
      if (clk_q) begin
        n_d = i_div_n;
      end
    end else begin
      cnt_d = cnt_q + DIV_WIDTH'(1);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      cnt_q <= '0;
      n_q <= DIV_WIDTH'(DIV_RESET);
      clk_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      n_q <= n_d;
      clk_q <= clk_d;
    end
  end

  assign o_clk = clk_q;
endmodule : mhp_clk_div

// File: rtl/mhp_edge_sync.sv
// two-flop synchroniser with rising edge detector
`timescale 1ns/1ps
module mhp_edge_sync (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_async,
  output logic o_level,
  output logic o_rise
);
  logic meta_q, meta_d;
  logic sync_q, sync_d;
  logic prev_q, prev_d;

  always_comb begin
    meta_d = i_async;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  // meta_q feeds only sync_q; the edge looks at settled samples
  assign o_level = sync_q;
  assign o_rise = sync_q & ~prev_q;
endmodule : mhp_edge_sync

// File: rtl/mhp_pin_functions.sv
// modem host pin functions: apb registers, pin mux, clock out, events
`timescale 1ns/1ps

module mhp_pin_functions
  import mhp_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire mhp_apb_req_type i_apb,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire logic [NUM_PINS-1:0] i_pins,
  output mhp_pins_type o_pins,
  output logic o_divided_clock_out,
  input wire logic i_secondary_serial_out,
  output logic o_secondary_serial_in,
  input wire logic i_rx_frame_end_flag,
  input wire logic i_connect,
  input wire logic i_carrier_lost,
  input wire logic i_intrusion,
  input wire logic i_rx_space,
  output logic o_cts,
  output logic o_online,
  output logic o_sleep,
  output logic o_irq
);
  // register state
  logic [DIV_W-1:0] div_q, div_d;
  logic [7:0] pin_func_q, pin_func_d;
  logic [3:0] gpio_dir_q, gpio_dir_d;
  logic [3:0] gpio_out_q, gpio_out_d;
  logic [2:0] mode_q, mode_d;
  logic [IRQ_W-1:0] irq_stat_q, irq_stat_d;
  logic [IRQ_W-1:0] irq_en_q, irq_en_d;
  // block state
  logic online_q, online_d;
  logic evt_q, evt_d;
  logic irq_q, irq_d;
  logic cts_q, cts_d;
  logic sec_rx_q, sec_rx_d;
  logic [3:0] gpio_in_q, gpio_in_d;
  mhp_pins_type pins_q, pins_d;
  // apb answer
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;

  logic access;
  logic wr_fire;
  logic esc_rise;
  logic esc_level;
  logic clk_out;
  logic esc_mode;
  logic evt_mode;
  logic evt_set;
  logic esc_evt;
  logic hit;
  logic [31:0] rd_word;

  // pin mux and four-bit gpio fields serve exactly four pins
  if (NUM_PINS != 4 || IRQ_W < 3) begin : g_bad_cfg
    $error("mhp_pin_functions: unsupported pin or interrupt count");
  end

  mhp_edge_sync u_esc_sync (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_async(i_pins[2]),
    .o_level(esc_level),
    .o_rise(esc_rise)
  );

  mhp_clk_div #(
    .DIV_WIDTH(DIV_W)
  ) u_clk_div (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_div_n(div_q),
    .o_clk(clk_out)
  );

  // zero-wait decode, one wait state so read data comes from a flop
  assign access = i_apb.psel & i_apb.penable;
  // writes land on the edge at which the master samples ready high
  assign wr_fire = access & pready_q & i_apb.pwrite;

  assign esc_mode = pin_func_q[PF_ESC_BIT];
  assign evt_mode = (pin_func_q[PF_EVT_LSB +: 2] == PF_EVT_ON);
  // an edge while offline is dropped, not kept for the next call
  assign esc_evt = esc_mode & esc_rise & online_q;
  assign evt_set = evt_mode & (i_carrier_lost | i_intrusion);

  // read mux
  always_comb begin
    rd_word = RDATA_ZERO;
    hit = 1'b1;
    unique case (i_apb.paddr)
      OFS_DIVIDER: rd_word[DIV_W-1:0] = div_q;
      OFS_PIN_FUNC: rd_word[7:0] = pin_func_q;
      OFS_GPIO_DIR: rd_word[3:0] = gpio_dir_q;
      OFS_GPIO_OUT: rd_word[3:0] = gpio_out_q;
      OFS_GPIO_IN: rd_word[3:0] = gpio_in_q;
      OFS_MODE: rd_word[2:0] = mode_q;
      OFS_STATUS: begin
        rd_word[ST_ONLINE_BIT] = online_q;
        rd_word[ST_SLEEP_BIT] = mode_q[MODE_SLEEP_BIT];
        rd_word[ST_CTS_BIT] = cts_q;
        rd_word[ST_EVT_BIT] = evt_q;
      end
      OFS_IRQ_STAT: rd_word[IRQ_W-1:0] = irq_stat_q;
      OFS_IRQ_EN: rd_word[IRQ_W-1:0] = irq_en_q;
      // clear register is write-only, reads zero
      OFS_IRQ_CLR: rd_word = RDATA_ZERO;
      default: hit = 1'b0;
    endcase
  end

  // apb slave answer
  always_comb begin
    pready_d = access & ~pready_q;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    if (access & ~pready_q) begin
      prdata_d = i_apb.pwrite ? RDATA_ZERO : rd_word;
      pslverr_d = ~hit;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      pready_q <= 1'b0;
      prdata_q <= RDATA_ZERO;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= pready_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // software registers
  always_comb begin
    div_d = div_q;
    pin_func_d = pin_func_q;
    gpio_dir_d = gpio_dir_q;
    gpio_out_d = gpio_out_q;
    mode_d = mode_q;
    irq_en_d = irq_en_q;
    if (wr_fire) begin
      unique case (i_apb.paddr)
        OFS_DIVIDER: div_d = i_apb.pwdata[DIV_W-1:0];
        OFS_PIN_FUNC: pin_func_d = i_apb.pwdata[7:0];
        OFS_GPIO_DIR: gpio_dir_d = i_apb.pwdata[3:0];
        OFS_GPIO_OUT: gpio_out_d = i_apb.pwdata[3:0];
        OFS_MODE: mode_d = i_apb.pwdata[2:0];
        OFS_IRQ_EN: irq_en_d = i_apb.pwdata[IRQ_W-1:0];
        // read-only and unmapped offsets keep all state
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      div_q <= DIV_RESET;
      pin_func_q <= PIN_FUNC_RESET;
      gpio_dir_q <= GPIO_RESET;
      gpio_out_q <= GPIO_RESET;
      mode_q <= MODE_RESET;
      irq_en_q <= '0;
    end else begin
      div_q <= div_d;
      pin_func_q <= pin_func_d;
      gpio_dir_q <= gpio_dir_d;
      gpio_out_q <= gpio_out_d;
      mode_q <= mode_d;
      irq_en_q <= irq_en_d;
    end
  end

  // modem state, sticky line event and interrupts
  always_comb begin
    logic [IRQ_W-1:0] clr;
    logic [IRQ_W-1:0] ev;
    clr = '0;
    ev = '0;
    if (wr_fire && i_apb.paddr == OFS_IRQ_CLR) begin
      clr = i_apb.pwdata[IRQ_W-1:0];
    end
    ev[IRQ_ESC_BIT] = esc_evt;
    ev[IRQ_EVT_BIT] = evt_set & ~evt_q;
    ev[IRQ_LOSS_BIT] = i_carrier_lost;
    // events win over a clear in the same cycle
    irq_stat_d = (irq_stat_q & ~clr) | ev;
    irq_d = |(irq_stat_q & irq_en_q);
    online_d = online_q;
    // loss beats connect so a dropped line never reads as online
    if (esc_evt || i_carrier_lost) begin
      online_d = 1'b0;
    end else if (i_connect) begin
      online_d = 1'b1;
    end
    evt_d = evt_q;
    if (wr_fire && i_apb.paddr == OFS_PIN_FUNC) begin
      evt_d = 1'b0;
    end
    if (evt_set) begin
      evt_d = 1'b1;
    end
    // no data accepted while asleep
    cts_d = i_rx_space & ~mode_q[MODE_SLEEP_BIT];
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      irq_stat_q <= '0;
      irq_q <= 1'b0;
      online_q <= 1'b0;
      evt_q <= 1'b0;
      cts_q <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_q <= irq_d;
      online_q <= online_d;
      evt_q <= evt_d;
      cts_q <= cts_d;
    end
  end

  // pin mux
  always_comb begin
    pins_d.dout = gpio_out_q;
    pins_d.oe = gpio_dir_q;
    gpio_in_d = i_pins;
    // pin three read back through the synchroniser in escape mode
    if (esc_mode) begin
      gpio_in_d[2] = esc_level;
    end
    sec_rx_d = 1'b1;
    // hdlc owns pin one over the secondary serial transmit line
    if (mode_q[MODE_HDLC_BIT]) begin
      pins_d.dout[0] = i_rx_frame_end_flag;
      pins_d.oe[0] = 1'b1;
    end else if (mode_q[MODE_SEC_BIT]) begin
      pins_d.dout[0] = i_secondary_serial_out;
      pins_d.oe[0] = 1'b1;
    end
    if (mode_q[MODE_SEC_BIT]) begin
      pins_d.dout[1] = 1'b0;
      pins_d.oe[1] = 1'b0;
      sec_rx_d = i_pins[1];
    end
    if (esc_mode) begin
      pins_d.dout[2] = 1'b0;
      pins_d.oe[2] = 1'b0;
    end
    if (evt_mode) begin
      pins_d.dout[3] = evt_q;
      pins_d.oe[3] = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      pins_q <= '0;
      gpio_in_q <= GPIO_RESET;
      sec_rx_q <= 1'b1;
    end else begin
      pins_q <= pins_d;
      gpio_in_q <= gpio_in_d;
      sec_rx_q <= sec_rx_d;
    end
  end

  assign o_pready = pready_q;
  assign o_prdata = prdata_q;
  assign o_pslverr = pslverr_q;
  assign o_pins = pins_q;
  assign o_divided_clock_out = clk_out;
  assign o_secondary_serial_in = sec_rx_q;
  assign o_cts = cts_q;
  assign o_online = online_q;
  assign o_sleep = mode_q[MODE_SLEEP_BIT];
  assign o_irq = irq_q;
endmodule : mhp_pin_functions

// File: rtl/mhp_pkg.sv
// shared constants and types of the modem host pin function block
package mhp_pkg;
  // reference, multiplied and system clock, in hertz
  localparam int unsigned REF_CLK_HZ = 4915200;
  localparam int unsigned PLL_CLK_HZ = 78643200;
  localparam int unsigned SYS_CLK_HZ = 25000000;

  // divided clock output
  localparam int DIV_W = 5;
  localparam logic [4:0] DIV_RESET = 5'h07;
  localparam logic [4:0] DIV_STOP = 5'h00;

  // number of multi-function pins
  localparam int NUM_PINS = 4;

  // apb register byte offsets
  localparam logic [7:0] OFS_DIVIDER = 8'h00;
  localparam logic [7:0] OFS_PIN_FUNC = 8'h04;
  localparam logic [7:0] OFS_GPIO_DIR = 8'h08;
  localparam logic [7:0] OFS_GPIO_OUT = 8'h0C;
  localparam logic [7:0] OFS_GPIO_IN = 8'h10;
  localparam logic [7:0] OFS_MODE = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
  localparam logic [7:0] OFS_IRQ_EN = 8'h20;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h24;

  // pin function register fields
  localparam int PF_ESC_BIT = 3;
  localparam int PF_EVT_LSB = 6;
  localparam logic [1:0] PF_EVT_ON = 2'h3;
  localparam logic [7:0] PIN_FUNC_RESET = 8'h00;

  // mode register fields
  localparam int MODE_SEC_BIT = 0;
  localparam int MODE_HDLC_BIT = 1;
  localparam int MODE_SLEEP_BIT = 2;
  localparam logic [2:0] MODE_RESET = 3'h0;

  // status register fields
  localparam int ST_ONLINE_BIT = 0;
  localparam int ST_SLEEP_BIT = 1;
  localparam int ST_CTS_BIT = 2;
  localparam int ST_EVT_BIT = 3;

  // interrupt status bits
  localparam int IRQ_W = 3;
  localparam int IRQ_ESC_BIT = 0;
  localparam int IRQ_EVT_BIT = 1;
  localparam int IRQ_LOSS_BIT = 2;

  localparam logic [3:0] GPIO_RESET = 4'h0;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [NUM_PINS-1:0] dout;
    logic [NUM_PINS-1:0] oe;
  } mhp_pins_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } mhp_apb_req_type;
endpackage : mhp_pkg
